/* File: dsw_regs.svh */
// Constants for the serial DAC write port
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH
`define DSW_FRAME_WIDE 24
`define DSW_FRAME_NARROW 16
`define DSW_EXEC_WIDE 18
`define DSW_EXEC_NARROW 16
`define DSW_MODE_W 2
`define DSW_CODE_W 16
`define DSW_NARROW_CODE_W 14
`define DSW_CODE_RESET 16'h0000
`define DSW_MODE_RESET 2'h0
`define DSW_GAP_NS 20
`define DSW_CLK_NS 20
`define DSW_DIV_DEFAULT 4
`define DSW_SEL_HOLD_CYC ((`DSW_GAP_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)
// Host command port
`define DSW_ADDR_CMD 4'h0
`define DSW_ADDR_STAT 4'h4
`define DSW_ADDR_ECHO 4'h8
`endif

/* File: dsw_pkg.sv */
// Types for the two ends of the serial DAC write port: device power modes and host states
package dsw_pkg;
  typedef enum logic [1:0] {
    DSW_PWR_NORMAL = 2'h0,
    DSW_PWR_GND_1K = 2'h1,
    DSW_PWR_GND_100K = 2'h2,
    DSW_PWR_HIZ = 2'h3
  } dsw_pwr_t;
  typedef enum logic [1:0] {
    DSW_H_IDLE = 2'h0,
    DSW_H_SHIFT = 2'h1,
    DSW_H_GAP = 2'h3
  } dsw_host_st_t;
endpackage

/* File: dsw_link_if.sv */
// Three-wire link between host master and DAC port
interface dsw_link_if;
  logic sync_n;
  logic sclk;
  logic sdin;
  modport host (output sync_n, output sclk, output sdin);
  modport dev (input sync_n, input sclk, input sdin);
endinterface

/* File: dsw_sync2.sv */
// Two-flop synchroniser with falling-edge detect on the second stage
module dsw_sync2 #(
  parameter logic INIT = 1'b1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic fell
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign level = s2_reg;
  assign fell = s3_reg & ~s2_reg;
endmodule

/* File: dsw_dev.sv */
// Device end: serial input shift register, DAC register and power mode
//
// Chosen here: the plain strobed port and the address map.
`include "dsw_regs.svh"
module dsw_dev #(
  parameter bit WIDE = 1'b1
) (
  input wire logic clock,
  input wire logic rstn,
  dsw_link_if.dev link,
  output logic [`DSW_CODE_W-1:0] dac_code,
  output dsw_pkg::dsw_pwr_t pwr_mode,
  output logic out_active,
  output logic update_pulse,
  output logic abort_pulse
);
  localparam int FRAME_W = WIDE ? `DSW_FRAME_WIDE : `DSW_FRAME_NARROW;
  localparam int EXEC_N = WIDE ? `DSW_EXEC_WIDE : `DSW_EXEC_NARROW;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] EXEC_CNT = CNT_W'(EXEC_N);
  localparam logic [CNT_W-1:0] LAST_BEFORE = CNT_W'(EXEC_N - 1);

  logic sel_level;
  logic sel_fell;
  logic sclk_level;
  logic sclk_fell;
  logic din_level;
  dsw_sync2 #(.INIT(1'b1)) u_sel (
    .clock(clock), .rstn(rstn), .pin(link.sync_n), .level(sel_level), .fell(sel_fell));
  dsw_sync2 #(.INIT(1'b0)) u_sclk (
    .clock(clock), .rstn(rstn), .pin(link.sclk), .level(sclk_level), .fell(sclk_fell));
  dsw_sync2 #(.INIT(1'b0)) u_din (
    .clock(clock), .rstn(rstn), .pin(link.sdin), .level(din_level), .fell());

  // shift register of the variant's width
  logic [FRAME_W-1:0] shift_reg;
  logic [FRAME_W-1:0] shift_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic armed_reg;
  logic armed_next;
  logic [`DSW_CODE_W-1:0] code_reg;
  logic [`DSW_CODE_W-1:0] code_next;
  dsw_pkg::dsw_pwr_t mode_reg;
  dsw_pkg::dsw_pwr_t mode_next;
  logic upd_reg;
  logic abt_reg;

  // only a fresh select fall arms the port
  wire start = sel_fell;
  // sample on each falling serial clock while armed and selected
  wire take_bit = armed_reg & ~sel_level & sclk_fell & ~start;
  // execute on the fixed edge count
  wire exec = take_bit & (cnt_reg == LAST_BEFORE);
  // select rise before the execute edge
  wire abort = armed_reg & sel_level;
  // msb first: new bit enters at the bottom
  wire [FRAME_W-1:0] shifted = {shift_reg[FRAME_W-2:0], din_level};

  // Full command word as seen at the execute edge, left aligned
  wire [EXEC_N-1:0] cmd_word = shifted[EXEC_N-1:0];
  wire [1:0] cmd_mode = cmd_word[EXEC_N-1 -: `DSW_MODE_W];
  wire [`DSW_CODE_W-1:0] cmd_code;
  generate
    if (WIDE) begin : g_wide
      // code bits follow the two mode bits
      assign cmd_code = cmd_word[`DSW_CODE_W-1:0];
    end else begin : g_narrow
      assign cmd_code = {2'h0, cmd_word[`DSW_NARROW_CODE_W-1:0]};
    end
  endgenerate

  always_comb begin
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    armed_next = armed_reg;
    code_next = code_reg;
    mode_next = mode_reg;
    if (start) begin
      shift_next = '0;
      cnt_next = '0;
      armed_next = 1'b1;
    end else if (abort) begin
      // abort clears the shifter, leaves code and mode
      shift_next = '0;
      cnt_next = '0;
      armed_next = 1'b0;
    end else if (take_bit) begin
      shift_next = shifted;
      cnt_next = cnt_reg + CNT_W'(1);
      if (exec) begin
        // disarm; trailing bits are ignored until next fall
        armed_next = 1'b0;
        code_next = cmd_code;
        mode_next = dsw_pkg::dsw_pwr_t'(cmd_mode);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
      cnt_reg <= '0;
      armed_reg <= 1'b0;
      // zero code, normal mode after reset
      code_reg <= `DSW_CODE_RESET;
      mode_reg <= dsw_pkg::dsw_pwr_t'(`DSW_MODE_RESET);
      upd_reg <= 1'b0;
      abt_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      armed_reg <= armed_next;
      code_reg <= code_next;
      mode_reg <= mode_next;
      upd_reg <= exec & ~start;
      abt_reg <= abort & ~start;
    end
  end

  logic act_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      act_reg <= 1'b1;
    end else begin
      act_reg <= (mode_next == dsw_pkg::DSW_PWR_NORMAL);
    end
  end

  assign dac_code = code_reg;
  assign pwr_mode = mode_reg;
  assign out_active = act_reg;
  assign update_pulse = upd_reg;
  assign abort_pulse = abt_reg;
  // EXEC_CNT documents the execute edge count in falling edges
  wire unused_ok = &{1'b0, EXEC_CNT};
endmodule

/* File: dsw_host.sv */
// Host end: serial master with a small command port
`include "dsw_regs.svh"
module dsw_host #(
  parameter bit WIDE = 1'b1,
  parameter int DIV = `DSW_DIV_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  dsw_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  localparam int FRAME_W = WIDE ? `DSW_FRAME_WIDE : `DSW_FRAME_NARROW;
  localparam int CNT_W = 5;
  localparam int HOLD = `DSW_SEL_HOLD_CYC < 1 ? 1 : `DSW_SEL_HOLD_CYC;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(FRAME_W - 1);
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] GAP_LAST = 8'(HOLD * DIV);

  dsw_pkg::dsw_host_st_t st_reg;
  dsw_pkg::dsw_host_st_t st_next;
  logic [FRAME_W-1:0] word_reg;
  logic [31:0] echo_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [7:0] div_reg;
  logic phase_reg;
  logic sync_n_reg;
  logic sclk_reg;
  logic sdin_reg;
  logic [31:0] rdata_reg;

  wire tick = (div_reg == DIV_LAST);
  wire busy = (st_reg != dsw_pkg::DSW_H_IDLE);
  wire go = wr & (addr == `DSW_ADDR_CMD) & ~busy;
  wire last_bit = (bit_reg == LAST);
  // data set on rising edge, taken by the device on falling edge
  wire fall_edge = tick & phase_reg & (st_reg == dsw_pkg::DSW_H_SHIFT);
  wire rise_edge = tick & ~phase_reg & (st_reg == dsw_pkg::DSW_H_SHIFT);
  // Select stays low half a period past the last fall, then rises
  wire gap_rise = tick & ~phase_reg & (st_reg == dsw_pkg::DSW_H_GAP);
  wire gap_done = tick & phase_reg & (st_reg == dsw_pkg::DSW_H_GAP);
  wire [31:0] rd_mux = (addr == `DSW_ADDR_STAT) ? {31'h0, busy} :
                       (addr == `DSW_ADDR_ECHO) ? echo_reg : 32'h0;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      dsw_pkg::DSW_H_IDLE: if (go) st_next = dsw_pkg::DSW_H_SHIFT;
      dsw_pkg::DSW_H_SHIFT: if (fall_edge & last_bit) st_next = dsw_pkg::DSW_H_GAP;
      // select high at least 20 ns before the next frame
      dsw_pkg::DSW_H_GAP: if (gap_done) st_next = dsw_pkg::DSW_H_IDLE;
      default: st_next = dsw_pkg::DSW_H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= dsw_pkg::DSW_H_IDLE;
      word_reg <= '0;
      echo_reg <= 32'h0;
      bit_reg <= '0;
      div_reg <= 8'h0;
      phase_reg <= 1'b0;
      sync_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      sdin_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      rdata_reg <= rd ? rd_mux : 32'h0;
      div_reg <= (go | tick) ? 8'h0 : div_reg + 8'h1;
      if (go) begin
        // whole frame in one select low, msb at the top
        word_reg <= wdata[FRAME_W-1:0];
        echo_reg <= wdata;
        bit_reg <= '0;
        phase_reg <= 1'b0;
        sync_n_reg <= 1'b0;
        sdin_reg <= wdata[FRAME_W-1];
      end else if (rise_edge) begin
        sclk_reg <= 1'b1;
        phase_reg <= 1'b1;
        // bit launched on the rising edge, steady across the fall
        sdin_reg <= word_reg[FRAME_W-1];
      end else if (fall_edge) begin
        sclk_reg <= 1'b0;
        phase_reg <= 1'b0;
        word_reg <= {word_reg[FRAME_W-2:0], 1'b0};
        bit_reg <= bit_reg + CNT_W'(1);
      end else if (gap_rise) begin
        // Rising with the last fall would look like an abort to the port
        sync_n_reg <= 1'b1;
        phase_reg <= 1'b1;
      end
    end
  end

  wire unused_gap = &{1'b0, GAP_LAST};
  assign link.sync_n = sync_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdin = sdin_reg;
  assign rdata = rdata_reg;
endmodule

/* File: dsw_assertions.sv */
// Concurrent checks on the joined link and the wide device outputs
module dsw_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic update_pulse,
  input wire logic abort_pulse,
  input wire logic [15:0] dac_code,
  input wire dsw_pkg::dsw_pwr_t pwr_mode,
  input wire logic out_active
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_IDLE_LOW: assert property (sync_n |-> !sclk)
    else $error("sclk high outside frame");
  // Bench instantiates the host with a four cycle half period
  AST_HALF: assert property ($rose(sclk) |-> sclk[*4])
    else $error("sclk high phase wrong length");
  AST_FALL_IN: assert property ($fell(sclk) |-> !sync_n)
    else $error("sclk fell outside frame");
  AST_EXEC_TIME: assert property ($fell(sync_n) |-> ##[140:160] update_pulse)
    else $error("update not on eighteenth fall");
  AST_EXEC_LOW: assert property (update_pulse |-> !sync_n)
    else $error("update after select rose");
  AST_ONE_UPD: assert property (update_pulse |=> !update_pulse[*8])
    else $error("second update in frame");
  AST_CODE_CAUSE: assert property ($changed(dac_code) |-> $past(update_pulse) || update_pulse)
    else $error("code changed without update");
  AST_MODE_CAUSE: assert property ($changed(pwr_mode) |-> $past(update_pulse) || update_pulse)
    else $error("mode changed without update");
  AST_ACTIVE: assert property (out_active == (pwr_mode == dsw_pkg::DSW_PWR_NORMAL))
    else $error("active flag disagrees with mode");
  AST_EXCL: assert property (!(update_pulse && abort_pulse))
    else $error("update and abort together");
endmodule

/* File: test_dac_serial_write_port.sv */
// Bench: host joined to a wide device, bench drives a narrow device
`include "dsw_regs.svh"
module test_dac_serial_write_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, wr, rd, sclk_d, sdin_d;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [23:0] cap;
  logic [15:0] dac_code, n_code;
  dsw_pkg::dsw_pwr_t pwr_mode, n_mode;
  logic out_active, update_pulse, abort_pulse, n_act, n_upd, n_abt;
  int mismatches, checks_done, upd_n, abt_n, ec, em, k;
  dsw_link_if link();
  dsw_link_if nlink();
  dsw_host #(.WIDE(1'b1), .DIV(4)) u_dsw_host (.clock(clock), .rstn(rstn), .link(link.host),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  dsw_dev #(.WIDE(1'b1)) u_dsw_dev (.clock(clock), .rstn(rstn), .link(link.dev),
    .dac_code(dac_code), .pwr_mode(pwr_mode), .out_active(out_active),
    .update_pulse(update_pulse), .abort_pulse(abort_pulse));
  dsw_dev #(.WIDE(1'b0)) u_dsw_dev_n (.clock(clock), .rstn(rstn), .link(nlink.dev),
    .dac_code(n_code), .pwr_mode(n_mode), .out_active(n_act),
    .update_pulse(n_upd), .abort_pulse(n_abt));
  dsw_assertions u_dsw_assertions (.clock(clock), .rstn(rstn), .sync_n(link.sync_n),
    .sclk(link.sclk), .update_pulse(update_pulse), .abort_pulse(abort_pulse),
    .dac_code(dac_code), .pwr_mode(pwr_mode), .out_active(out_active));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Capture the bit held while sclk was high
  always @(posedge clock) begin
    sclk_d <= link.sclk;
    sdin_d <= link.sdin;
    if (sclk_d && !link.sclk) cap <= {cap[22:0], sdin_d};
    if (n_upd === 1'b1) upd_n++;
    if (n_abt === 1'b1) abt_n++;
  end
  task automatic give_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
    checks_done++;
    if (e !== s) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(int i, int lim);
    if (i >= lim) begin
      chk("wait", 1, 0);
      give_verdict();
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic host_frame(logic [23:0] w);
    int i;
    wr_reg(`DSW_ADDR_CMD, {8'h00, w});
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      #1 if (update_pulse === 1'b1) break;
    end
    tmo(i, 400);
    @(posedge clock);
    #1 chk("code", w[21:6], dac_code);
    chk("mode", w[23:22], pwr_mode);
    chk("active", w[23:22] == 2'h0, out_active);
    for (i = 0; i < 300; i++) begin
      rd_reg(`DSW_ADDR_STAT);
      if (v[0] === 1'b0) break;
    end
    tmo(i, 300);
    chk("wire", w, cap);
    rd_reg(`DSW_ADDR_ECHO);
    chk("echo", w, v[23:0]);
  endtask
  // Narrow frame of n bits from w[23] down, longer pause before bit 8, select held low
  task automatic bb(logic [23:0] w, int n);
    int i, u0, a0;
    u0 = upd_n;
    a0 = abt_n;
    @(posedge clock);
    nlink.sync_n <= 1'b0;
    for (i = 0; i < n; i++) begin
      repeat (i == 8 ? 10 : 4) @(posedge clock);
      nlink.sclk <= 1'b1;
      nlink.sdin <= w[23-i];
      repeat (4) @(posedge clock);
      nlink.sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    nlink.sync_n <= 1'b1;
    nlink.sdin <= ~nlink.sdin;
    // Select high 160 ns before the checks, 180 ns before the next frame
    repeat (8) @(posedge clock);
    if (n >= 16) begin
      ec = w[21:8];
      em = w[23:22];
    end
    chk("ncode", ec, n_code);
    chk("nmode", em, n_mode);
    chk("nupd", n >= 16, upd_n - u0);
    chk("nabort", n < 16, abt_n - a0);
    chk("nactive", em == 0, n_act);
  endtask
  initial begin
    rstn = 1'b0;
    {addr, wdata, wr, rd, ec, em, mismatches, checks_done} = '0;
    nlink.sync_n = 1'b1;
    nlink.sclk = 1'b0;
    nlink.sdin = 1'b0;
    void'($urandom(32'h2226));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("code", 0, dac_code);
    for (k = 0; k < 4; k++) host_frame({k[1:0], 16'($urandom), 6'($urandom)});
    host_frame(24'hBFFFC0);
    rd_reg(4'hC);
    chk("unmapped", 0, v[23:0]);
    bb({16'($urandom), 8'h00}, 16);
    bb(24'hFFFF00, 15);
    bb({16'($urandom), 8'hA5}, 24);
    bb(24'h7FFF00, 1);
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    #1 chk("code", 0, dac_code);
    chk("ncode", 0, n_code);
    give_verdict();
  end
endmodule
